/* include/ftw_pkg.sv */
/*
  Shared constants and types for the radio-unit fronthaul timing-window block.
  Assumes every time value is an unsigned count of nanoseconds on the common
  timescale. The timescale wraps, and differences are taken modulo 2^TIME_W.
*/
package ftw_pkg;

  // ==========================================================================
  // widths and buffer depth
  localparam int TIME_W = 32;
  localparam int TE_W = 16;
  localparam int CNT_W = 16;
  localparam int DATA_W_DEF = 32;
  localparam int FIFO_DEPTH_DEF = 8;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [TIME_W-1:0] TOD_STEP_NS = TIME_W'(CLK_PERIOD_NS);
  localparam int SYNC_TE_TOTAL_NS = 3000;
  localparam int SYNC_TE_HALF_NS = SYNC_TE_TOTAL_NS / 2;
  localparam logic signed [TE_W-1:0] SYNC_TE_LIM = TE_W'(SYNC_TE_HALF_NS);

  // ==========================================================================
  // fixed radio-unit window defaults, in ns (plain values)
  localparam logic [TIME_W-1:0] T2AMIN_NS_DEF = 32'h0001_86A0;
  localparam logic [TIME_W-1:0] T2AMAX_NS_DEF = 32'h0003_F7A0;
  localparam logic [TIME_W-1:0] TA3MIN_NS_DEF = 32'h0000_C350;
  localparam logic [TIME_W-1:0] TA3MAX_NS_DEF = 32'h0002_49F0;

  // ==========================================================================
  // reset values and counter ceiling
  localparam logic [TIME_W-1:0] TOD_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {CLS_EARLY, CLS_ON_TIME, CLS_LATE} ftw_class_t;
  typedef enum logic [1:0] {UL_IDLE, UL_WAIT, UL_SEND} ftw_ul_state_t;

endpackage

/* hdl/ftw_timing_window.sv */
/*
  Radio-unit fronthaul timing-window logic and its downlink buffer FIFO.
  Assumes a sync-plane agent on the same clock that loads the common time
  and reports the time error. Upstream parsing supplies each packet's air
  instant. All inputs come from logic on i_sys_clk.
*/
// Overview of operation
// - transport delay in each direction is handled as a min/max range, never as one value.
// - every send and receive instant is an offset from the fixed antenna point.
// - transport delay counts only from leaving one interface to arriving at the other.
// - the receiver keeps a reception window in which a symbol's packets still make the air.
// - a reception window is at least the transmission window plus the transport variation.
// - radio-unit windows are fixed relative to the air; only distributed-unit windows move.
// - both ends compute every window position on one common timescale.
// - the time error between the units should stay within plus or minus 1.5 us.
`timescale 1ns/1ns

// ============================================================================
// fifo: parameterised width and depth, valid/ready on both sides
module ftw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire wr_en;
  wire rd_en;
  // an honest full and empty: ready drops at depth, valid only with data
  assign o_in_ready = (count_q != DEPTH_C);
  assign o_out_valid = (count_q != '0);
  assign wr_en = i_ce & i_in_valid & o_in_ready;
  assign rd_en = i_ce & o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_ptr_q];
  // storage holds no reset, only the pointers and count do
  always_ff @(posedge i_sys_clk) begin
    if (wr_en) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end
  // pointers wrap by compare, so depth need not be a power of two
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
      end
      if (wr_en && !rd_en) begin
        count_q <= count_q + 1'b1;
      end else if (rd_en && !wr_en) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // ftw_fifo

// ============================================================================
// top: time base, window checks, downlink classifier, uplink send gate
module ftw_timing_window import ftw_pkg::*; #(
  parameter int DATA_W = DATA_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [TIME_W-1:0] T2AMIN_NS = T2AMIN_NS_DEF,
  parameter logic [TIME_W-1:0] T2AMAX_NS = T2AMAX_NS_DEF,
  parameter logic [TIME_W-1:0] TA3MIN_NS = TA3MIN_NS_DEF,
  parameter logic [TIME_W-1:0] TA3MAX_NS = TA3MAX_NS_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_tod_load,
  input wire logic [TIME_W-1:0] i_tod_value,
  input wire logic signed [TE_W-1:0] i_sync_te_ns,
  output logic [TIME_W-1:0] o_tod,
  output logic o_sync_ok,
  input wire logic [TIME_W-1:0] i_t12_min,
  input wire logic [TIME_W-1:0] i_t12_max,
  input wire logic [TIME_W-1:0] i_t34_min,
  input wire logic [TIME_W-1:0] i_t34_max,
  input wire logic [TIME_W-1:0] i_t1a_min,
  input wire logic [TIME_W-1:0] i_t1a_max,
  input wire logic [TIME_W-1:0] i_ta4_min,
  input wire logic [TIME_W-1:0] i_ta4_max,
  output logic [TIME_W-1:0] o_t1a_max_lim,
  output logic [TIME_W-1:0] o_t1a_min_lim,
  output logic [TIME_W-1:0] o_ta4_min_lim,
  output logic [TIME_W-1:0] o_ta4_max_lim,
  output logic o_dl_win_ok,
  output logic o_ul_win_ok,
  input wire logic i_dl_valid,
  output logic o_dl_ready,
  input wire logic [TIME_W-1:0] i_dl_air_time,
  input wire logic [DATA_W-1:0] i_dl_data,
  output logic o_dl_out_valid,
  input wire logic i_dl_out_ready,
  output logic [TIME_W-1:0] o_dl_out_air_time,
  output logic [DATA_W-1:0] o_dl_out_data,
  output logic o_dl_early,
  output logic o_dl_late,
  output logic [CNT_W-1:0] o_dl_early_cnt,
  output logic [CNT_W-1:0] o_dl_late_cnt,
  input wire logic i_ul_valid,
  output logic o_ul_ready,
  input wire logic [TIME_W-1:0] i_ul_air_time,
  input wire logic [DATA_W-1:0] i_ul_data,
  output logic o_ul_tx_valid,
  input wire logic i_ul_tx_ready,
  output logic [DATA_W-1:0] o_ul_tx_data,
  output logic o_ul_late,
  output logic [CNT_W-1:0] o_ul_late_cnt
);
  localparam int FW = TIME_W + DATA_W;
  logic [TIME_W-1:0] tod_q;
  logic sync_ok_q;
  logic [TIME_W-1:0] t1a_max_lim_q, t1a_min_lim_q, ta4_min_lim_q, ta4_max_lim_q;
  logic dl_win_ok_q, ul_win_ok_q;
  logic dl_early_q, dl_late_q, ul_late_q;
  logic [CNT_W-1:0] dl_early_cnt_q, dl_late_cnt_q, ul_late_cnt_q;
  ftw_ul_state_t ul_state_q;
  logic [TIME_W-1:0] ul_air_q;
  logic [DATA_W-1:0] ul_data_q;

  // ==========================================================================
  // common time base: each enabled cycle, loaded by the sync agent, else advanced one period
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tod_q <= TOD_RST;
    end else if (i_ce) begin
      tod_q <= i_tod_load ? i_tod_value : tod_q + TOD_STEP_NS;
    end
  end
  assign o_tod = tod_q;
  // time error check; the magnitude test avoids negating the most negative value
  wire te_ok = (i_sync_te_ns <= SYNC_TE_LIM) && (i_sync_te_ns >= -SYNC_TE_LIM);

  // ==========================================================================
  // window bounds advertised to the distributed unit; transport is a range
  wire [TIME_W-1:0] t1a_max_lim_d = T2AMAX_NS + i_t12_min;
  wire [TIME_W-1:0] t1a_min_lim_d = T2AMIN_NS + i_t12_max;
  wire [TIME_W-1:0] ta4_min_lim_d = TA3MIN_NS + i_t34_min;
  wire [TIME_W-1:0] ta4_max_lim_d = TA3MAX_NS + i_t34_max;
  // widths carry one extra bit so that large sums cannot wrap into a pass
  wire [TIME_W:0] t2a_win = {1'b0, T2AMAX_NS - T2AMIN_NS};
  wire [TIME_W:0] ta4_win = {1'b0, i_ta4_max - i_ta4_min};
  wire [TIME_W:0] dl_need = {1'b0, i_t1a_max - i_t1a_min} + {1'b0, i_t12_max - i_t12_min};
  wire [TIME_W:0] ul_need = {1'b0, TA3MAX_NS - TA3MIN_NS} + {1'b0, i_t34_max - i_t34_min};
  wire dl_ok_d = (i_t1a_max >= i_t1a_min) && (i_t12_max >= i_t12_min)
               && (t2a_win >= dl_need)
               && (i_t1a_max <= t1a_max_lim_d) && (i_t1a_min >= t1a_min_lim_d);
  wire ul_ok_d = (i_ta4_max >= i_ta4_min) && (i_t34_max >= i_t34_min)
               && (ta4_win >= ul_need)
               && (i_ta4_min <= ta4_min_lim_d) && (i_ta4_max >= ta4_max_lim_d);
  // registered check results, refreshed every enabled cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync_ok_q <= 1'b0;
      {t1a_max_lim_q, t1a_min_lim_q, ta4_min_lim_q, ta4_max_lim_q} <= '0;
      dl_win_ok_q <= 1'b0;
      ul_win_ok_q <= 1'b0;
    end else if (i_ce) begin
      sync_ok_q <= te_ok;
      {t1a_max_lim_q, t1a_min_lim_q} <= {t1a_max_lim_d, t1a_min_lim_d};
      {ta4_min_lim_q, ta4_max_lim_q} <= {ta4_min_lim_d, ta4_max_lim_d};
      dl_win_ok_q <= dl_ok_d;
      ul_win_ok_q <= ul_ok_d;
    end
  end
  assign o_sync_ok = sync_ok_q;
  assign {o_t1a_max_lim, o_t1a_min_lim} = {t1a_max_lim_q, t1a_min_lim_q};
  assign {o_ta4_min_lim, o_ta4_max_lim} = {ta4_min_lim_q, ta4_max_lim_q};
  assign o_dl_win_ok = dl_win_ok_q;
  assign o_ul_win_ok = ul_win_ok_q;
  // ==========================================================================
  // downlink classifier: lead before air time measured on the shared timescale
  // lead is the arrival at the receive interface relative to the antenna point
  wire signed [TIME_W-1:0] dl_lead = $signed(i_dl_air_time - tod_q);
  wire dl_is_early = (dl_lead > $signed(T2AMAX_NS));
  wire dl_is_late = (dl_lead < $signed(T2AMIN_NS));
  ftw_class_t dl_class;
  assign dl_class = dl_is_early ? CLS_EARLY : (dl_is_late ? CLS_LATE : CLS_ON_TIME);
  wire fifo_in_ready;
  // out-of-window packets are also held off while the buffer is full: simpler
  // than a bypass, at the cost of a full buffer stalling drops too
  assign o_dl_ready = fifo_in_ready;
  wire dl_take = i_ce & i_dl_valid & fifo_in_ready;
  wire fifo_wr = i_dl_valid & (dl_class == CLS_ON_TIME);

  ftw_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_dl_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_in_valid(fifo_wr),
    .o_in_ready(fifo_in_ready),
    .i_in_data({i_dl_air_time, i_dl_data}),
    .o_out_valid(o_dl_out_valid),
    .i_out_ready(i_dl_out_ready),
    .o_out_data({o_dl_out_air_time, o_dl_out_data})
  );

  // pulse flags and saturating counters for packets outside the window
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      dl_early_q <= 1'b0;
      dl_late_q <= 1'b0;
      dl_early_cnt_q <= CNT_RST;
      dl_late_cnt_q <= CNT_RST;
    end else if (i_ce) begin
      dl_early_q <= dl_take && (dl_class == CLS_EARLY);
      dl_late_q <= dl_take && (dl_class == CLS_LATE);
      if (dl_take && dl_class == CLS_EARLY && dl_early_cnt_q != CNT_MAX) begin
        dl_early_cnt_q <= dl_early_cnt_q + 1'b1;
      end
      if (dl_take && dl_class == CLS_LATE && dl_late_cnt_q != CNT_MAX) begin
        dl_late_cnt_q <= dl_late_cnt_q + 1'b1;
      end
    end
  end
  assign o_dl_early = dl_early_q;
  assign o_dl_late = dl_late_q;
  assign o_dl_early_cnt = dl_early_cnt_q;
  assign o_dl_late_cnt = dl_late_cnt_q;

  // ==========================================================================
  // uplink gate: a symbol leaves between Ta3min and one period past Ta3max after antenna receipt
  wire signed [TIME_W-1:0] ul_elapsed = $signed(tod_q - ul_air_q);
  wire ul_open = (ul_elapsed >= $signed(TA3MIN_NS));
  wire ul_expired = (ul_elapsed > $signed(TA3MAX_NS));
  assign o_ul_ready = (ul_state_q == UL_IDLE);
  assign o_ul_tx_valid = (ul_state_q == UL_SEND);
  assign o_ul_tx_data = ul_data_q;

  // one symbol in flight; an expired one is dropped, unless the far side's ready arrives in its expiry cycle, when it is sent
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ul_state_q <= UL_IDLE;
      ul_air_q <= TOD_RST;
      ul_data_q <= '0;
      ul_late_q <= 1'b0;
      ul_late_cnt_q <= CNT_RST;
    end else if (i_ce) begin
      ul_late_q <= 1'b0;
      case (ul_state_q)
        UL_IDLE: begin
          if (i_ul_valid) begin
            ul_air_q <= i_ul_air_time;
            ul_data_q <= i_ul_data;
            ul_state_q <= UL_WAIT;
          end
        end
        UL_WAIT: begin
          if (ul_expired) begin
            ul_late_q <= 1'b1;
            ul_state_q <= UL_IDLE;
          end else if (ul_open) begin
            ul_state_q <= UL_SEND;
          end
        end
        UL_SEND: begin
          if (i_ul_tx_ready) begin
            ul_state_q <= UL_IDLE;
          end else if (ul_expired) begin
            ul_late_q <= 1'b1;
            ul_state_q <= UL_IDLE;
          end
        end
        default: begin
          ul_state_q <= UL_IDLE;
        end
      endcase
      if (ul_expired && !(ul_state_q == UL_SEND && i_ul_tx_ready)
          && ul_state_q != UL_IDLE && ul_late_cnt_q != CNT_MAX) begin
        ul_late_cnt_q <= ul_late_cnt_q + 1'b1;
      end
    end
  end
  assign o_ul_late = ul_late_q;
  assign o_ul_late_cnt = ul_late_cnt_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  AST_DL_EARLY_FLAG: assert property (dl_take && dl_is_early |=> o_dl_early)
    else $error("early packet not flagged");
  AST_DL_LATE_DROP: assert property (dl_take && dl_is_late && !o_dl_out_valid
    |=> !o_dl_out_valid)
    else $error("late packet written to buffer");
  AST_DL_ONTIME_KEEP: assert property (dl_take && !dl_is_early && !dl_is_late
    |=> o_dl_out_valid)
    else $error("on-time packet not buffered");
  AST_DL_WIN_REL: assert property ($past(i_ce) && dl_win_ok_q
    |-> $past(i_t1a_max) <= o_t1a_max_lim && $past(i_t1a_min) >= o_t1a_min_lim)
    else $error("downlink window ok against violated bounds");
  AST_UL_NOT_EARLY: assert property (o_ul_tx_valid |-> ul_elapsed >= $signed(TA3MIN_NS))
    else $error("uplink symbol offered before window");
  AST_UL_EXPIRE: assert property (i_ce && ul_state_q == UL_WAIT && ul_expired
    |=> o_ul_late && o_ul_ready)
    else $error("expired uplink symbol not dropped");
  AST_SYNC_TE: assert property (i_ce && (i_sync_te_ns > SYNC_TE_LIM) |=> !o_sync_ok)
    else $error("time error beyond limit reported ok");
  AST_TOD_STEP: assert property (i_ce && !i_tod_load |=> o_tod == $past(o_tod) + TOD_STEP_NS)
    else $error("time base did not advance by one period");
  AST_FULL_STALL: assert property (!o_dl_ready
    |=> $stable(o_dl_early_cnt) || !$past(i_ce) || $past(o_dl_ready))
    else $error("packet counted while buffer full");

  COV_DL_EARLY: cover property (dl_take && dl_is_early);
  COV_DL_LATE: cover property (dl_take && dl_is_late);
  COV_UL_SENT: cover property (o_ul_tx_valid && i_ul_tx_ready && i_ce);
  COV_DL_FULL: cover property (i_dl_valid && !o_dl_ready);
endmodule // ftw_timing_window

/* dv/ftw_du_model.sv */
/*
  Distributed-unit model: sends downlink symbols toward the block and takes
  uplink symbols from it. Assumes its tasks are called at a rising clock edge.
*/
`timescale 1ns/1ns
// ==========
// far side of the fronthaul link
module ftw_du_model import ftw_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic [TIME_W-1:0] i_tod,
  input wire logic i_dl_ready,
  output logic o_dl_valid,
  output logic [TIME_W-1:0] o_dl_air_time,
  output logic [31:0] o_dl_data,
  input wire logic i_ul_tx_valid,
  output logic o_ul_tx_ready,
  input wire logic [31:0] i_ul_tx_data
);
  logic ul_stall;
  logic [31:0] ul_got;
  logic [7:0] ul_cnt;

  // idle lines carry junk, so a late sample never looks like a packet
  initial begin
    o_dl_valid = 1'b0;
    o_dl_air_time = 32'h5A5A_5A5A;
    o_dl_data = 32'hA5A5_A5A5;
    o_ul_tx_ready = 1'b0;
    ul_stall = 1'b0;
    ul_got = 32'h0000_0000;
    ul_cnt = 8'h00;
  end

  // one parameter set only: this model faces a single radio unit
  // places a symbol lead ns ahead of its air instant on the shared time
  task automatic send(input logic [TIME_W-1:0] lead, input logic [31:0] data);
    logic rdy;
    o_dl_valid <= 1'b1;
    o_dl_air_time <= i_tod + TOD_STEP_NS + lead;
    o_dl_data <= data;
    do begin
      @(negedge i_sys_clk);
      rdy = i_dl_ready;
      @(posedge i_sys_clk);
    end while (!rdy);
  endtask

  // release the lines with inverted values
  task automatic idle();
    o_dl_valid <= 1'b0;
    o_dl_air_time <= ~o_dl_air_time;
    o_dl_data <= ~o_dl_data;
  endtask

  // uplink sink; ready lags the stall knob by one edge like a registered port
  always @(posedge i_sys_clk) begin
    o_ul_tx_ready <= !ul_stall;
    if (i_ul_tx_valid && o_ul_tx_ready) begin
      ul_got <= i_ul_tx_data;
      ul_cnt <= ul_cnt + 8'h01;
    end
  end
endmodule // ftw_du_model

/* dv/tb_ftw_timing_window.sv */
/*
  Self-checking bench for the timing-window block.
  Assumes the distributed-unit model drives downlink input and sinks uplink.
*/
`timescale 1ns/1ns
// ==========
// bench top
module tb_ftw_timing_window import ftw_pkg::*;;
  logic clk, rst, ce, tod_load, dl_valid, dl_ready, dl_out_valid, dl_out_ready;
  logic dl_early, dl_late, ul_valid, ul_ready, ul_tx_valid, ul_tx_ready, ul_late;
  logic sync_ok, dl_win_ok, ul_win_ok;
  logic signed [TE_W-1:0] te;
  logic [TIME_W-1:0] tod_value, tod, t12_min, t12_max, t34_min, t34_max;
  logic [TIME_W-1:0] t1a_min, t1a_max, ta4_min, ta4_max, lim1, lim2, lim3, lim4;
  logic [TIME_W-1:0] dl_air, dl_out_air, ul_air_time;
  logic [31:0] dl_data, dl_out_data, ul_data, ul_tx_data;
  logic [CNT_W-1:0] early_cnt, late_cnt, ul_late_cnt;
  int fail_count, n_checks;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ftw_timing_window i_ftw_timing_window (.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(ce),
    .i_tod_load(tod_load), .i_tod_value(tod_value), .i_sync_te_ns(te), .o_tod(tod),
    .o_sync_ok(sync_ok), .i_t12_min(t12_min), .i_t12_max(t12_max), .i_t34_min(t34_min),
    .i_t34_max(t34_max), .i_t1a_min(t1a_min), .i_t1a_max(t1a_max), .i_ta4_min(ta4_min),
    .i_ta4_max(ta4_max), .o_t1a_max_lim(lim1), .o_t1a_min_lim(lim2), .o_ta4_min_lim(lim3),
    .o_ta4_max_lim(lim4), .o_dl_win_ok(dl_win_ok), .o_ul_win_ok(ul_win_ok),
    .i_dl_valid(dl_valid), .o_dl_ready(dl_ready), .i_dl_air_time(dl_air), .i_dl_data(dl_data),
    .o_dl_out_valid(dl_out_valid), .i_dl_out_ready(dl_out_ready),
    .o_dl_out_air_time(dl_out_air),
    .o_dl_out_data(dl_out_data), .o_dl_early(dl_early), .o_dl_late(dl_late),
    .o_dl_early_cnt(early_cnt), .o_dl_late_cnt(late_cnt), .i_ul_valid(ul_valid),
    .o_ul_ready(ul_ready), .i_ul_air_time(ul_air_time), .i_ul_data(ul_data),
    .o_ul_tx_valid(ul_tx_valid), .i_ul_tx_ready(ul_tx_ready), .o_ul_tx_data(ul_tx_data),
    .o_ul_late(ul_late), .o_ul_late_cnt(ul_late_cnt));

  ftw_du_model i_ftw_du_model (.i_sys_clk(clk), .i_tod(tod), .i_dl_ready(dl_ready),
    .o_dl_valid(dl_valid), .o_dl_air_time(dl_air), .o_dl_data(dl_data),
    .i_ul_tx_valid(ul_tx_valid), .o_ul_tx_ready(ul_tx_ready), .i_ul_tx_data(ul_tx_data));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk("tod", 32'h0, tod);
    chk("ready", 32'h3, {30'h0, dl_ready, ul_ready});
    chk("counts", 32'h0, {early_cnt, late_cnt | ul_late_cnt});
    $display("test reset done");
  endtask

  // load near the top, freeze with enable low, then wrap
  task automatic t_tod();
    @(posedge clk);
    tod_load <= 1'b1;
    tod_value <= 32'hFFFF_FFE2;
    @(posedge clk);
    tod_load <= 1'b0;
    @(negedge clk);
    chk("tod load", 32'hFFFF_FFE2, tod);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk("tod frozen", 32'hFFFF_FFEC, tod);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("tod wrap", 32'h0000_000A, tod);
    $display("test tod done");
  endtask

  task automatic lim_chk(input logic dl_exp, input logic ul_exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("dl window ok", 32'(dl_exp), 32'(dl_win_ok));
    chk("ul window ok", 32'(ul_exp), 32'(ul_win_ok));
  endtask

  // windows sized exactly at the width bound, then nudged past each limit
  task automatic t_limits();
    @(posedge clk);
    t12_min <= 32'h0000_C350;
    t12_max <= 32'h0000_C738;
    t34_min <= 32'h0000_C350;
    t34_max <= 32'h0000_C738;
    t1a_max <= 32'h0004_BAF0;
    t1a_min <= 32'h0002_4DD8;
    ta4_max <= 32'h0003_1128;
    ta4_min <= 32'h0001_86A0;
    lim_chk(1'b1, 1'b1);
    chk("t1a max lim", T2AMAX_NS_DEF + 32'h0000_C350, lim1);
    chk("t1a min lim", T2AMIN_NS_DEF + 32'h0000_C738, lim2);
    chk("ta4 min lim", TA3MIN_NS_DEF + 32'h0000_C350, lim3);
    chk("ta4 max lim", TA3MAX_NS_DEF + 32'h0000_C738, lim4);
    @(posedge clk);
    t1a_max <= 32'h0004_BAFA;
    ta4_min <= 32'h0001_86AA;
    lim_chk(1'b0, 1'b0);
    @(posedge clk);
    t1a_max <= 32'h0004_BAF0;
    t1a_min <= 32'h0002_4DCE;
    ta4_min <= 32'h0001_86A0;
    ta4_max <= 32'h0003_111E;
    lim_chk(1'b0, 1'b0);
    $display("test limits done");
  endtask

  task automatic t_sync();
    logic [TE_W-1:0] tev [4] = '{16'h05DC, 16'h05DD, 16'hFA24, 16'hFA23};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      te <= tev[k];
      @(posedge clk);
      @(negedge clk);
      chk("sync ok", 32'(k % 2 == 0), 32'(sync_ok));
    end
    $display("test sync done");
  endtask

  // both window edges inclusive, one ns outside each is refused
  task automatic t_dl_class();
    logic [31:0] lead [4];
    lead = '{T2AMIN_NS_DEF - 32'h1, T2AMIN_NS_DEF, T2AMAX_NS_DEF, T2AMAX_NS_DEF + 32'h1};
    @(posedge clk);
    dl_out_ready <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      i_ftw_du_model.send(lead[k], 32'(k));
      i_ftw_du_model.idle();
      @(negedge clk);
      chk("dl late", 32'(k == 0), 32'(dl_late));
      chk("dl early", 32'(k == 3), 32'(dl_early));
      chk("dl on time", 32'(k == 1 || k == 2), 32'(dl_out_valid));
      if (k == 1 || k == 2) chk("dl data", 32'(k), dl_out_data);
      if (k == 1 || k == 2) chk("dl air", lead[k] - TOD_STEP_NS, dl_out_air - tod);
    end
    @(negedge clk);
    chk("dl counts", 32'h0001_0001, {early_cnt, late_cnt});
    chk("dl early pulse", 32'h0, 32'(dl_early));
    $display("test dl class done");
  endtask

  // fill with the consumer stalled, then drain in order
  task automatic t_fifo();
    @(posedge clk);
    dl_out_ready <= 1'b0;
    for (int k = 0; k < FIFO_DEPTH_DEF; k++) begin
      i_ftw_du_model.send(T2AMIN_NS_DEF + 32'h0000_1000, 32'h0000_0100 + 32'(k));
    end
    i_ftw_du_model.idle();
    @(negedge clk);
    chk("fifo full", 32'h1, {31'h0, !dl_ready & dl_out_valid});
    @(posedge clk);
    dl_out_ready <= 1'b1;
    for (int k = 0; k < FIFO_DEPTH_DEF; k++) begin
      @(negedge clk);
      chk("fifo order", 32'h0000_0100 + 32'(k), dl_out_data);
      @(posedge clk);
    end
    @(negedge clk);
    chk("fifo empty", 32'h1, {31'h0, !dl_out_valid & dl_ready});
    $display("test fifo done");
  endtask

  task automatic ul_run(input logic [31:0] elapsed, input logic [31:0] data,
                        output int lates, output int txs);
    lates = 0;
    txs = 0;
    @(posedge clk);
    ul_valid <= 1'b1;
    ul_air_time <= tod + TOD_STEP_NS - elapsed;
    ul_data <= data;
    @(posedge clk);
    ul_valid <= 1'b0;
    ul_air_time <= ~ul_air_time;
    ul_data <= ~data;
    repeat (40) begin
      @(negedge clk);
      if (ul_late === 1'b1) lates++;
      if (ul_tx_valid === 1'b1) txs++;
    end
  endtask

  // prompt send, already expired, and expiry while the far side stalls
  task automatic t_ul();
    int lates, txs;
    ul_run(TA3MIN_NS_DEF, 32'hC0DE_0001, lates, txs);
    chk("ul sent", 32'h0001_0001, {16'(lates == 0), 16'(txs == 1)});
    chk("ul data", 32'hC0DE_0001, i_ftw_du_model.ul_got);
    ul_run(TA3MAX_NS_DEF + 32'h1, 32'hC0DE_0002, lates, txs);
    chk("ul expired", 32'h0001_0000, {16'(lates), 16'(txs)});
    @(posedge clk);
    i_ftw_du_model.ul_stall <= 1'b1;
    ul_run(TA3MAX_NS_DEF - 32'h0000_0032, 32'hC0DE_0003, lates, txs);
    chk("ul stalled", 32'h0001_0001, {16'(lates), 16'(txs > 0)});
    chk("ul taken", 32'h1, 32'(i_ftw_du_model.ul_cnt));
    chk("ul late count", 32'h2, 32'(ul_late_cnt));
    i_ftw_du_model.ul_stall <= 1'b0;
    $display("test ul done");
  endtask

  // reset again in mid-run: time base, counters and handshakes must clear
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
  endtask

  // ==========
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tod_load = 1'b0;
    tod_value = 32'h0000_0000;
    te = 16'h0000;
    {t12_min, t12_max, t34_min, t34_max} = '0;
    {t1a_min, t1a_max, ta4_min, ta4_max} = '0;
    dl_out_ready = 1'b0;
    ul_valid = 1'b0;
    ul_air_time = 32'h0000_0000;
    ul_data = 32'h0000_0000;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tod();
    t_limits();
    t_sync();
    t_dl_class();
    t_fifo();
    t_ul();
    t_rerst();
    give_verdict();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict();
  end
endmodule // tb_ftw_timing_window
